/* logic/capture_compare_timer16_consts.vh */
/*
 * Constants of the 16-bit capture/compare timer: register indices, field
 * positions, reset values and the prescale figure.
 * Assumes an APB slave with 32-bit data; each register index sits at byte
 * address four times the index, 8-bit data in the low byte.
 */
// Overview of operation
// - counter advances every four clocks via fixed prescaler, wraps after 262,144 clocks.
// - software may read the counter anytime without disturbing counting.
// - capture and compare values appear as high and low 8-bit registers.
// - active capture pin edge copies the counter into the capture pair, except from capture high read until capture low read.
// - edge select 1 means rising, 0 falling; reset leaves it unchanged.
// - counter is compared with the compare pair every fourth clock.
// - on match compare pin takes level select bit; reset clears that bit.
// - capture interrupt enable bit, read/write, cleared by reset.
// - compare interrupt enable bit, read/write, cleared by reset.
// - overflow interrupt enable bit, read/write, cleared by reset.
// - capture flag clears after status read with flag set, then capture low read.
// - compare flag clears after status read with flag set, then compare low access.
// - overflow flag clears after status read with flag set, then counter low read.
// - writing compare high byte suppresses matches until compare low byte written.
`ifndef CAPTURE_COMPARE_TIMER16_CONSTS_VH
`define CAPTURE_COMPARE_TIMER16_CONSTS_VH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define CCT_IDX_CONTROL      6'h12
`define CCT_IDX_FLAGS        6'h13
`define CCT_IDX_CAPTURE_HI   6'h14
`define CCT_IDX_CAPTURE_LO   6'h15
`define CCT_IDX_COMPARE_HI   6'h16
`define CCT_IDX_COMPARE_LO   6'h17
`define CCT_IDX_COUNTER_HI   6'h18
`define CCT_IDX_COUNTER_LO   6'h19
`define CCT_IDX_ALT_HI       6'h1A
`define CCT_IDX_ALT_LO       6'h1B
`define CCT_IDX_FLAG_CLEAR   6'h1C

// ----------------------------------------------------------------------
// field positions (control and flags share the top three bits)
// ----------------------------------------------------------------------
`define CCT_BIT_CAPTURE      7
`define CCT_BIT_COMPARE      6
`define CCT_BIT_OVERFLOW     5
`define CCT_BIT_EDGE         1
`define CCT_BIT_LEVEL        0

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define CCT_COUNTER_RESET    16'hFFFC
`define CCT_COMPARE_RESET    16'hFFFF
`define CCT_PRESCALE         4

`endif

/* logic/clock_prescaler.v */
/*
 * Fixed divider: one-cycle enable pulse every DIV clocks.
 * Assumes a single clock domain and asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module clock_prescaler
#(
    parameter DIV = 4,
    parameter W   = 2
)
(
    input  wire pclk,
    input  wire presetn,
    output reg  tick
);

    localparam [W-1:0] LAST = DIV[W-1:0] - 1'b1;

    reg [W-1:0] phase;

    // ----------------------------------------------------------------------
    // phase counter, pulse on the last phase
    // ----------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= {W{1'b0}};
            tick  <= 1'b0;
        end
        else
        begin
            tick <= (phase == LAST);
            if (phase == LAST)
                phase <= {W{1'b0}};
            else
                phase <= phase + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

/* logic/pin_edge_sync.v */
/*
 * Four-flop synchroniser for an asynchronous pin with edge pulses.
 * Assumes the pin is unrelated to pclk; edges are seen from the second,
 * third and fourth stages only, so the first stage never feeds any decision.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_edge_sync
(
    input  wire pclk,
    input  wire presetn,
    input  wire pin,
    output wire rise,
    output wire fall
);

    reg stage1;
    reg stage2;
    reg stage3;
    reg stage4;

    // ----------------------------------------------------------------------
    // shift chain; a change counts once stage2 and stage3 agree
    // ----------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            stage4 <= 1'b0;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            stage4 <= stage3;
        end
    end

    assign rise = stage2 & stage3 & ~stage4;
    assign fall = ~stage2 & ~stage3 & stage4;

endmodule

`default_nettype wire

/* logic/capture_compare_timer16.v */
/*
 * 16-bit free-running timer with one input capture and one output compare
 * channel, registers on an APB slave (zero wait states).
 * Assumes pclk at 40 MHz, asynchronous active-low presetn, and an external
 * capture pin that is asynchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_timer16_consts.vh"

module capture_compare_timer16
#(
    parameter AW = 8
)
(
    input  wire          pclk,
    input  wire          presetn,
    input  wire [AW-1:0] paddr,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output reg           pslverr,
    input  wire          capture_input_pin,
    output reg           compare_output_pin,
    output wire          timer_irq
);

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    reg  [15:0] count;
    reg  [15:0] capture_value;
    reg  [15:0] compare_value;
    reg  [7:0]  counter_lo_hold;
    reg         counter_lo_held;
    reg  [7:0]  alt_lo_hold;
    reg         alt_lo_held;
    reg         capture_inhibit;
    reg         compare_inhibit;
    reg         capture_irq_enable;
    reg         compare_irq_enable;
    reg         overflow_irq_enable;
    reg         capture_edge_select;
    reg         output_level_select;
    reg         capture_flag;
    reg         compare_match_flag;
    reg         overflow_flag;
    reg         capture_armed;
    reg         compare_armed;
    reg         overflow_armed;
    reg  [7:0]  next_rdata;
    reg         next_mapped;

    wire        tick;
    wire        pin_rise;
    wire        pin_fall;
    wire [5:0]  idx;
    wire        setup;
    wire        access;
    wire        rd;
    wire        wr;
    wire        edge_hit;
    wire        match_hit;
    wire        wrap_hit;
    wire [7:0]  control_view;
    wire [7:0]  flags_view;
    wire [7:0]  wbyte;

    // ----------------------------------------------------------------------
    // leaves
    // ----------------------------------------------------------------------
    clock_prescaler
    #(
        .DIV (`CCT_PRESCALE),
        .W   (2)
    )
    u_prescaler
    (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    pin_edge_sync u_capture_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (capture_input_pin),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // ----------------------------------------------------------------------
    // bus decode; zero wait states, so pready stays high
    // ----------------------------------------------------------------------
    assign idx    = paddr[7:2];
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign rd     = access & ~pwrite & ~pslverr;
    assign wr     = access & pwrite & ~pslverr;
    assign pready = 1'b1;
    assign wbyte  = pwdata[7:0];

    assign control_view = {capture_irq_enable, compare_irq_enable, overflow_irq_enable,
                           3'b000, capture_edge_select, output_level_select};
    assign flags_view   = {capture_flag, compare_match_flag, overflow_flag, 5'b00000};

    // ----------------------------------------------------------------------
    // timer events
    // ----------------------------------------------------------------------
    assign edge_hit  = (capture_edge_select ? pin_rise : pin_fall) & ~capture_inhibit;
    assign match_hit = tick & ~compare_inhibit & (count == compare_value);
    assign wrap_hit  = tick & (count == 16'hFFFF);

    // level interrupt: any flag whose enable is set
    assign timer_irq = (capture_flag & capture_irq_enable)
                     | (compare_match_flag & compare_irq_enable)
                     | (overflow_flag & overflow_irq_enable);

    // ----------------------------------------------------------------------
    // read mux, sampled in the setup cycle
    // ----------------------------------------------------------------------
    always @*
    begin
        next_rdata  = 8'h00;
        next_mapped = (paddr[1:0] == 2'b00) && ((paddr >> 8) == 0);
        case (idx)
            `CCT_IDX_CONTROL:    next_rdata = control_view;
            `CCT_IDX_FLAGS:      next_rdata = flags_view;
            `CCT_IDX_CAPTURE_HI: next_rdata = capture_value[15:8];
            `CCT_IDX_CAPTURE_LO: next_rdata = capture_value[7:0];
            `CCT_IDX_COMPARE_HI: next_rdata = compare_value[15:8];
            `CCT_IDX_COMPARE_LO: next_rdata = compare_value[7:0];
            `CCT_IDX_COUNTER_HI: next_rdata = count[15:8];
            `CCT_IDX_COUNTER_LO: next_rdata = counter_lo_held ? counter_lo_hold : count[7:0];
            `CCT_IDX_ALT_HI:     next_rdata = count[15:8];
            `CCT_IDX_ALT_LO:     next_rdata = alt_lo_held ? alt_lo_hold : count[7:0];
            `CCT_IDX_FLAG_CLEAR: next_rdata = 8'h00;                 // write-only
            default:             next_mapped = 1'b0;
        endcase
    end

    // data and error come from flops set up one cycle before the access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= {24'h00_0000, next_rdata};
            pslverr <= ~next_mapped;
        end
        else if (!psel)
        begin
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // free-running counter; reads never touch it
    // ----------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= `CCT_COUNTER_RESET;
        else if (tick)
            count <= count + 16'h0001;
    end

    // ----------------------------------------------------------------------
    // counter low-byte holds: reading the high byte freezes the low byte
    // until it is read, so a two-byte read is coherent
    // ----------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter_lo_hold <= 8'h00;
            counter_lo_held <= 1'b0;
            alt_lo_hold     <= 8'h00;
            alt_lo_held     <= 1'b0;
        end
        else
        begin
            if (setup && !pwrite && idx == `CCT_IDX_COUNTER_HI)
            begin
                counter_lo_hold <= count[7:0];
                counter_lo_held <= 1'b1;
            end
            else if (rd && idx == `CCT_IDX_COUNTER_LO)
                counter_lo_held <= 1'b0;
            if (setup && !pwrite && idx == `CCT_IDX_ALT_HI)
            begin
                alt_lo_hold <= count[7:0];
                alt_lo_held <= 1'b1;
            end
            else if (rd && idx == `CCT_IDX_ALT_LO)
                alt_lo_held <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // input capture; reading the high byte blocks capture until low is read
    // ----------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_value   <= 16'h0000;
            capture_inhibit <= 1'b0;
        end
        else
        begin
            if (edge_hit)
                capture_value <= count;
            if (rd && idx == `CCT_IDX_CAPTURE_HI)
                capture_inhibit <= 1'b1;
            else if (rd && idx == `CCT_IDX_CAPTURE_LO)
                capture_inhibit <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // output compare; high-byte write stalls matching until the low byte
    // ----------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_value      <= `CCT_COMPARE_RESET;
            compare_inhibit    <= 1'b0;
            compare_output_pin <= 1'b0;
        end
        else
        begin
            if (wr && idx == `CCT_IDX_COMPARE_HI)
            begin
                compare_value[15:8] <= wbyte;
                compare_inhibit     <= 1'b1;
            end
            else if (wr && idx == `CCT_IDX_COMPARE_LO)
            begin
                compare_value[7:0] <= wbyte;
                compare_inhibit    <= 1'b0;
            end
            if (match_hit)
                compare_output_pin <= output_level_select;
        end
    end

    // ----------------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_irq_enable  <= 1'b0;
            compare_irq_enable  <= 1'b0;
            overflow_irq_enable <= 1'b0;
            output_level_select <= 1'b0;
        end
        else if (wr && idx == `CCT_IDX_CONTROL)
        begin
            capture_irq_enable  <= wbyte[`CCT_BIT_CAPTURE];
            compare_irq_enable  <= wbyte[`CCT_BIT_COMPARE];
            overflow_irq_enable <= wbyte[`CCT_BIT_OVERFLOW];
            output_level_select <= wbyte[`CCT_BIT_LEVEL];
        end
    end

    // edge select survives reset on purpose, so it has no reset branch
    always @(posedge pclk)
    begin
        if (wr && idx == `CCT_IDX_CONTROL)
            capture_edge_select <= wbyte[`CCT_BIT_EDGE];
    end

    // ----------------------------------------------------------------------
    // flags: a status read arms the clear, the low-byte access does it;
    // a new event in the clearing cycle wins
    // ----------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_flag       <= 1'b0;
            compare_match_flag <= 1'b0;
            overflow_flag      <= 1'b0;
            capture_armed      <= 1'b0;
            compare_armed      <= 1'b0;
            overflow_armed     <= 1'b0;
        end
        else
        begin
            if (rd && idx == `CCT_IDX_FLAGS)
            begin
                capture_armed  <= capture_flag;
                compare_armed  <= compare_match_flag;
                overflow_armed <= overflow_flag;
            end
            // capture flag
            if (edge_hit)
                capture_flag <= 1'b1;
            else if ((capture_armed && rd && idx == `CCT_IDX_CAPTURE_LO)
                     || (wr && idx == `CCT_IDX_FLAG_CLEAR && wbyte[`CCT_BIT_CAPTURE]))
            begin
                capture_flag  <= 1'b0;
                capture_armed <= 1'b0;
            end
            // compare flag: read or write of the low byte
            if (match_hit)
                compare_match_flag <= 1'b1;
            else if ((compare_armed && access && !pslverr && idx == `CCT_IDX_COMPARE_LO)
                     || (wr && idx == `CCT_IDX_FLAG_CLEAR && wbyte[`CCT_BIT_COMPARE]))
            begin
                compare_match_flag <= 1'b0;
                compare_armed      <= 1'b0;
            end
            // overflow flag: the alternate low byte does not clear it
            if (wrap_hit)
                overflow_flag <= 1'b1;
            else if ((overflow_armed && rd && idx == `CCT_IDX_COUNTER_LO)
                     || (wr && idx == `CCT_IDX_FLAG_CLEAR && wbyte[`CCT_BIT_OVERFLOW]))
            begin
                overflow_flag  <= 1'b0;
                overflow_armed <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* test/cct_props.sv */
/*
 * Port-level properties of the capture/compare timer.
 * Assumes an APB master that keeps the bus rules.
 */
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_timer16_consts.vh"

module cct_props
#(
    parameter AW = 8
)
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic [AW-1:0] paddr,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          capture_input_pin,
    input wire logic          compare_output_pin,
    input wire logic          timer_irq
);
    logic [7:0] ctl;
    logic       ctl_ok;
    logic       unmapped;
    logic       setup_rd;

    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    // shadow of control; edge select has no reset, so track the first write
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            ctl    <= 8'h00;
            ctl_ok <= 1'b0;
        end
        else if (psel && penable && pwrite && paddr == {`CCT_IDX_CONTROL, 2'b00})
        begin
            ctl    <= pwdata[7:0];
            ctl_ok <= 1'b1;
        end

    // decode seen in the setup cycle
    assign unmapped = (paddr[1:0] != 2'b00) || (paddr[AW-1:2] < `CCT_IDX_CONTROL)
                      || (paddr[AW-1:2] > `CCT_IDX_FLAG_CLEAR);
    assign setup_rd = psel && !penable && !pwrite;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence cap_rise;
        ctl_ok && ctl[7] && ctl[1] && $rose(capture_input_pin);
    endsequence

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    pready_const_a: assert property (pready)
        else $error("pready low");
    rdata_upper_a: assert property (prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    slverr_idle_a: assert property (!psel |=> !pslverr)
        else $error("error response without a transfer");
    slverr_map_a: assert property (psel && !penable |=> pslverr == $past(unmapped))
        else $error("error response does not match address decode");
    flags_zero_a: assert property (setup_rd && paddr == {`CCT_IDX_FLAGS, 2'b00} |=> prdata[4:0] == 5'h00)
        else $error("unused flag bits read nonzero");
    ctl_readback_a: assert property (ctl_ok && setup_rd && paddr == {`CCT_IDX_CONTROL, 2'b00}
        |=> prdata[7:0] == {ctl[7:5], 3'b000, ctl[1:0]})
        else $error("control read back differs");
    irq_flags_a: assert property (setup_rd && paddr == {`CCT_IDX_FLAGS, 2'b00}
        |=> (!(|(prdata[7:5] & ctl[7:5])) || timer_irq))
        else $error("enabled flag set but no interrupt");
    irq_needs_en_a: assert property (timer_irq |-> ctl[7:5] != 3'b000)
        else $error("interrupt with all enables clear");
    pin_level_a: assert property ($changed(compare_output_pin) |-> compare_output_pin == $past(ctl[0]))
        else $error("compare pin took a level other than the select bit");
    capture_irq_a: assert property (cap_rise |-> ##[2:6] timer_irq)
        else $error("active capture edge raised no interrupt");
endmodule

bind capture_compare_timer16 cct_props #(.AW(AW)) cct_props_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(capture_input_pin), .compare_output_pin(compare_output_pin),
    .timer_irq(timer_irq));

`default_nettype wire

/* test/pin_partner.sv */
/*
 * Far side of the timer: a waveform source on the capture pin and a load
 * on the compare pin that counts its rising edges.
 * Assumes the bench sets the wanted capture level; the pin moves off pclk's rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_partner
(
    input  wire logic       pclk,
    input  wire logic       want_level,
    input  wire logic       compare_output_pin,
    output var  logic       capture_input_pin,
    output var  logic [7:0] load_rises
);
    // source changes on the falling edge, so the pin is out of phase with sampling
    initial capture_input_pin = 1'b0;
    always @(negedge pclk)
        capture_input_pin <= want_level;

    // load side: rises are counted so a pin that toggles twice is caught
    initial load_rises = 8'h00;
    always @(posedge compare_output_pin)
        load_rises <= load_rises + 8'h01;
endmodule

`default_nettype wire

/* test/tb_top.sv */
/*
 * Self-checking bench: APB tasks and checks against expected values.
 * Assumes the timer and the pin partner model; clock 40 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
`include "capture_compare_timer16_consts.vh"

module tb_top;
    localparam logic [7:0] A_CTL = {`CCT_IDX_CONTROL, 2'b00};
    localparam logic [7:0] A_FLG = {`CCT_IDX_FLAGS, 2'b00};
    localparam logic [7:0] A_CHI = {`CCT_IDX_CAPTURE_HI, 2'b00};
    localparam logic [7:0] A_CLO = {`CCT_IDX_CAPTURE_LO, 2'b00};
    localparam logic [7:0] A_MHI = {`CCT_IDX_COMPARE_HI, 2'b00};
    localparam logic [7:0] A_MLO = {`CCT_IDX_COMPARE_LO, 2'b00};
    localparam logic [7:0] A_NHI = {`CCT_IDX_COUNTER_HI, 2'b00};
    localparam logic [7:0] A_NLO = {`CCT_IDX_COUNTER_LO, 2'b00};
    localparam logic [7:0] A_CLR = {`CCT_IDX_FLAG_CLEAR, 2'b00};
    logic        pclk, presetn, psel, penable, pwrite, want, err;
    logic        pready, pslverr, capture_input_pin, compare_output_pin, timer_irq;
    logic [7:0]  paddr, load_rises, n0;
    logic [31:0] pwdata, prdata, rd, r1, r2;
    logic [7:0]  ctl_vals [5] = '{8'h80, 8'h40, 8'h20, 8'h01, 8'hE3};
    int          fail_count, compares;

    capture_compare_timer16 #(.AW(8)) capture_compare_timer16_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_input_pin(capture_input_pin), .compare_output_pin(compare_output_pin),
        .timer_irq(timer_irq));
    pin_partner pin_partner_inst (
        .pclk(pclk), .want_level(want), .compare_output_pin(compare_output_pin),
        .capture_input_pin(capture_input_pin), .load_rises(load_rises));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------------
    // one APB transfer; the request is held until pready is seen high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h00_0000, d});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic results;
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog: the sequence needs about 1700 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        results;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, want} = 5'b00000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        fail_count = 0;
        compares = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(A_FLG, 32'h0000_0000);
        wr(A_CTL, 8'h02);
        rdchk(A_CTL, 32'h0000_0002);
        for (int i = 0; i < 5; i++)
        begin
            wr(A_CTL, ctl_vals[i]);
            rdchk(A_CTL, {24'h00_0000, ctl_vals[i]});
        end
        wr(A_CTL, 8'h02);
        xfer(8'h00, 1'b0, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        xfer(8'h49, 1'b0, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        // wrap and match at the reset compare value have happened
        rdchk(A_FLG, 32'h0000_0060);
        xfer(A_NLO, 1'b0, 32'h0000_0000);
        rdchk(A_MLO, 32'h0000_00FF);
        rdchk(A_FLG, 32'h0000_0000);
        // setups 40 clocks apart must see exactly ten counts
        xfer(A_NLO, 1'b0, 32'h0000_0000);
        r1 = rd;
        repeat (37) @(posedge pclk);
        xfer(A_NLO, 1'b0, 32'h0000_0000);
        chk({24'h00_0000, 8'(rd[7:0] - r1[7:0])}, 32'h0000_000A);
        // capture on a rising edge
        wr(A_CTL, 8'h82);
        xfer(A_NLO, 1'b0, 32'h0000_0000);
        r1 = rd;
        want <= 1'b1;
        repeat (8) @(posedge pclk);
        chk({31'h0, timer_irq}, 32'h0000_0001);
        rdchk(A_FLG, 32'h0000_0080);
        xfer(A_CHI, 1'b0, 32'h0000_0000);
        xfer(A_CLO, 1'b0, 32'h0000_0000);
        chk({31'h0, 8'(rd[7:0] - r1[7:0]) <= 8'h02}, 32'h0000_0001);
        rdchk(A_FLG, 32'h0000_0000);
        chk({31'h0, timer_irq}, 32'h0000_0000);
        want <= 1'b0;
        repeat (8) @(posedge pclk);
        rdchk(A_FLG, 32'h0000_0000);
        wr(A_CTL, 8'h80);
        want <= 1'b1;
        repeat (8) @(posedge pclk);
        rdchk(A_FLG, 32'h0000_0000);
        want <= 1'b0;
        repeat (8) @(posedge pclk);
        rdchk(A_FLG, 32'h0000_0080);
        wr(A_CTL, 8'h00);
        @(negedge pclk);
        chk({31'h0, timer_irq}, 32'h0000_0000);
        wr(A_CLR, 8'h80);
        rdchk(A_FLG, 32'h0000_0000);
        // compare 64 counts ahead, level high
        wr(A_CTL, 8'h41);
        xfer(A_NHI, 1'b0, 32'h0000_0000);
        r1 = rd;
        xfer(A_NLO, 1'b0, 32'h0000_0000);
        r2 = {16'h0000, r1[7:0], rd[7:0]} + 32'h0000_0040;
        n0 = load_rises;
        wr(A_MHI, r2[15:8]);
        wr(A_MLO, r2[7:0]);
        for (int k = 0; k < 1000 && compare_output_pin !== 1'b1; k++)
            @(posedge pclk);
        chk({31'h0, compare_output_pin}, 32'h0000_0001);
        chk({24'h00_0000, load_rises}, {24'h00_0000, 8'(n0 + 8'h01)});
        chk({31'h0, timer_irq}, 32'h0000_0001);
        rdchk(A_FLG, 32'h0000_0040);
        wr(A_MLO, r2[7:0]);
        rdchk(A_FLG, 32'h0000_0000);
        // high byte alone must hold matches off past the next hit
        wr(A_MHI, 8'(r2[15:8] + 8'h01));
        repeat (1200) @(posedge pclk);
        rdchk(A_FLG, 32'h0000_0000);
        wr(A_CTL, 8'hE3);
        presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        rdchk(A_CTL, 32'h0000_0002);
        results;
    end
endmodule

`default_nettype wire
